/* rtl/csoc_top.sv */
// Clock source selection and output enable control
//
// Summary of operation
// - Select pins 000-101 load settings; others reserved
// - Bypass bit lets external clock skip oscillator
// - Primary choice bit swaps crystal and external roles
// - Pick pin: 0 primary, 1 secondary source
// - Mode 0x manual, 10 auto, 11 auto-revertive
// - Polarity bit: 0 pin active low, 1 high
// - Shutdown-function bit lets pin stop synthesizers globally
// - Power-on bit 0 floats output unless global shutdown is in force
// - Gated output suspends while pin is inactive
// - Shutdown function plus pin high suspends everything
// - Suspended output drives high, low or floats
`timescale 1ns/10ps
`include "csoc_regs.svh"
module csoc_top (
   // Clock and reset
   input  wire logic                                     CLK_SYS,
   input  wire logic                                     RESET_N,
   // Setting selector pins
   input  wire logic [2:0]                               SETTING_SEL,
   // Source control
   input  wire logic                                     CRYSTAL_BYPASS,
   input  wire logic                                     PRIMARY_SOURCE_CHOICE,
   input  wire logic                                     SOURCE_PICK_PIN,
   input  wire logic [1:0]                               SWITCHOVER_MODE,
   input  wire logic                                     CRYSTAL_REF_OK,
   input  wire logic                                     EXTERNAL_CLOCK_OK,
   // Shutdown and gating control
   input  wire logic                                     SHUTDOWN_OR_GATE_PIN,
   input  wire logic                                     PIN_POLARITY,
   input  wire logic                                     SHUTDOWN_FUNCTION,
   input  wire csoc_pkg::csoc_out_cfg_t [`CSOC_NUM_OUTS-1:0] OUT_CFG,
   // Setting status
   output logic [2:0]                                    SETTING_INDEX,
   output logic                                          SETTING_LOAD,
   // Source status
   output logic                                          OSC_BYPASS,
   output logic                                          ACTIVE_EXTERNAL,
   output logic                                          ON_SECONDARY,
   // Output drive
   output logic                                          GLOBAL_SHUTDOWN,
   output logic [`CSOC_NUM_OUTS-1:0]                     CLOCK_OUTPUT_RUN,
   output logic [`CSOC_NUM_OUTS-1:0]                     CLOCK_OUTPUT_LEVEL,
   output logic [`CSOC_NUM_OUTS-1:0]                     CLOCK_OUTPUT_OE
);
   import csoc_pkg::*;

   // Drive decision for one output
   function automatic csoc_out_drv_t out_drive(input csoc_out_cfg_t cfg,
                                               input logic global_sd,
                                               input logic pin_suspend);
      csoc_out_drv_t d;
      d.run   = 1'b0;
      d.level = 1'b0;
      d.oe    = 1'b0;
      if (!global_sd && !cfg.power_on) begin
         // Unpowered floats whatever the level select says
         d.oe = 1'b0;
      end else if (!global_sd && !(cfg.gate && pin_suspend)) begin
         d.run = 1'b1;
         d.oe  = 1'b1;
      end else begin
         // Suspended: level select chooses low, high or float
         d.level = (cfg.dis_level == `CSOC_DIS_HIGH);
         d.oe    = (cfg.dis_level == `CSOC_DIS_LOW) || d.level;
      end
      return d;
   endfunction

   // Decoded control terms
   wire logic       sel_valid;     // Selector code not reserved
   wire logic       pin_suspend;   // Pin off its enabling level
   wire logic       global_sd;     // Global shutdown in force
   wire logic       prim_ok;       // Current primary reference present
   wire logic       sec_ok;        // Current secondary reference present
   wire logic       auto_mode;     // Automatic switching enabled
   wire logic       revert_mode;   // Return to primary allowed

   assign sel_valid   = (SETTING_SEL <= `CSOC_LAST_SETTING);
   // Active level enables gated outputs; the other level suspends them
   assign pin_suspend = SHUTDOWN_OR_GATE_PIN ^ PIN_POLARITY;
   assign global_sd   = SHUTDOWN_FUNCTION && SHUTDOWN_OR_GATE_PIN;
   assign prim_ok     = PRIMARY_SOURCE_CHOICE ? EXTERNAL_CLOCK_OK : CRYSTAL_REF_OK;
   assign sec_ok      = PRIMARY_SOURCE_CHOICE ? CRYSTAL_REF_OK : EXTERNAL_CLOCK_OK;
   assign auto_mode   = SWITCHOVER_MODE[`CSOC_AUTO_BIT];
   assign revert_mode = (SWITCHOVER_MODE == `CSOC_MODE_REVERT);

   // State and output registers
   csoc_src_t                  src_r;         // Primary or secondary in use
   csoc_src_t                  src_nxt;
   logic [2:0]                 setting_r;     // Loaded setting
   logic [2:0]                 setting_nxt;
   logic                       load_r;        // Setting changed pulse
   logic                       bypass_r;      // Oscillator bypass
   logic                       ext_r;         // External input is reference
   logic                       gsd_r;         // Global shutdown flag
   logic [`CSOC_NUM_OUTS-1:0]  run_r;         // Per-output run
   logic [`CSOC_NUM_OUTS-1:0]  lvl_r;         // Per-output static level
   logic [`CSOC_NUM_OUTS-1:0]  oe_r;          // Per-output enable
   logic [`CSOC_NUM_OUTS-1:0]  run_nxt;
   logic [`CSOC_NUM_OUTS-1:0]  lvl_nxt;
   logic [`CSOC_NUM_OUTS-1:0]  oe_nxt;

   // Reserved codes keep the present setting
   assign setting_nxt = sel_valid ? SETTING_SEL : setting_r;

   // Source switchover decision
   always_comb begin
      src_nxt = src_r;
      if (!auto_mode) begin
         // Manual: pin picks directly
         src_nxt = SOURCE_PICK_PIN ? CSOC_ON_SECONDARY : CSOC_ON_PRIMARY;
      end else begin
         case (src_r)
            CSOC_ON_PRIMARY: begin
               // Leave a lost primary if secondary is there
               if (!prim_ok && sec_ok) begin
                  src_nxt = CSOC_ON_SECONDARY;
               end
            end
            CSOC_ON_SECONDARY: begin
               // Only the revertive mode comes back
               if (revert_mode && prim_ok) begin
                  src_nxt = CSOC_ON_PRIMARY;
               end
            end
            default: begin
               src_nxt = CSOC_ON_PRIMARY;
            end
         endcase
      end
   end

   // Per-output drive decisions
   always_comb begin
      csoc_out_drv_t d;
      d       = '0;
      run_nxt = '0;
      lvl_nxt = '0;
      oe_nxt  = '0;
      for (int i = 0; i < `CSOC_NUM_OUTS; i++) begin
         d          = out_drive(OUT_CFG[i], global_sd, pin_suspend);
         run_nxt[i] = d.run;
         lvl_nxt[i] = d.level;
         oe_nxt[i]  = d.oe;
      end
   end

   // Source and setting registers
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         src_r     <= CSOC_ON_PRIMARY;
         setting_r <= `CSOC_RST_SETTING;
         load_r    <= 1'b0;
         bypass_r  <= 1'b0;
         ext_r     <= 1'b0;
      end else begin
         src_r     <= src_nxt;
         setting_r <= setting_nxt;
         load_r    <= (setting_nxt != setting_r);
         bypass_r  <= CRYSTAL_BYPASS;
         // External is reference when role and next source in use differ
         ext_r     <= (src_nxt == CSOC_ON_SECONDARY) ^ PRIMARY_SOURCE_CHOICE;
      end
   end

   // Output drive registers
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         gsd_r <= 1'b0;
         run_r <= '0;
         lvl_r <= '0;
         oe_r  <= '0;
      end else begin
         gsd_r <= global_sd;
         run_r <= run_nxt;
         lvl_r <= lvl_nxt;
         oe_r  <= oe_nxt;
      end
   end

   // Port drivers
   assign SETTING_INDEX      = setting_r;
   assign SETTING_LOAD       = load_r;
   assign OSC_BYPASS         = bypass_r;
   assign ACTIVE_EXTERNAL    = ext_r;
   assign ON_SECONDARY       = (src_r == CSOC_ON_SECONDARY);
   assign GLOBAL_SHUTDOWN    = gsd_r;
   assign CLOCK_OUTPUT_RUN   = run_r;
   assign CLOCK_OUTPUT_LEVEL = lvl_r;
   assign CLOCK_OUTPUT_OE    = oe_r;

   // Checks
   AST_SETTING_LOAD: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      sel_valid |=> SETTING_INDEX == $past(SETTING_SEL)) else $error("setting not loaded");
   AST_RESERVED_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      !sel_valid |=> $stable(SETTING_INDEX) && !SETTING_LOAD) else $error("reserved code changed setting");
   AST_BYPASS: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      CRYSTAL_BYPASS |=> OSC_BYPASS) else $error("bypass not applied");
   AST_MANUAL_REF: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      !auto_mode |=> ACTIVE_EXTERNAL == $past(SOURCE_PICK_PIN ^ PRIMARY_SOURCE_CHOICE))
      else $error("manual reference wrong");
   AST_AUTO_SWITCH: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      auto_mode && !ON_SECONDARY && !prim_ok && sec_ok |=> ON_SECONDARY) else $error("no switchover");
   AST_NO_REVERT: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      SWITCHOVER_MODE == `CSOC_MODE_AUTO && ON_SECONDARY |=> ON_SECONDARY) else $error("reverted in auto");
   AST_HIZ: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      !global_sd && !OUT_CFG[0].power_on |=> !CLOCK_OUTPUT_OE[0] && !CLOCK_OUTPUT_RUN[0])
      else $error("unpowered output driven");
   AST_GATED: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      !global_sd && OUT_CFG[0].power_on && OUT_CFG[0].gate |=> CLOCK_OUTPUT_RUN[0] == !$past(pin_suspend))
      else $error("gating wrong");
   AST_GLOBAL: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      SHUTDOWN_FUNCTION && SHUTDOWN_OR_GATE_PIN |=> GLOBAL_SHUTDOWN && CLOCK_OUTPUT_RUN == '0)
      else $error("global shutdown missed");
   AST_DIS_LEVEL: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      global_sd && OUT_CFG[0].dis_level == `CSOC_DIS_HIGH |=> CLOCK_OUTPUT_OE[0] && CLOCK_OUTPUT_LEVEL[0])
      else $error("disabled level wrong");
endmodule // csoc_top

/* rtl/csoc_regs.svh */
// Constants for the clock source and output control block
`ifndef CSOC_REGS_SVH
`define CSOC_REGS_SVH
`define CSOC_NUM_OUTS     6
`define CSOC_LAST_SETTING 3'h5
`define CSOC_RST_SETTING  3'h0
`define CSOC_MODE_AUTO    2'h2
`define CSOC_MODE_REVERT  2'h3
`define CSOC_AUTO_BIT     1
`define CSOC_DIS_LOW      2'h0
`define CSOC_DIS_HIGH     2'h1
`endif

/* rtl/csoc_pkg.sv */
// Types for the clock source and output control block
package csoc_pkg;
   // Per-output configuration bits
   typedef struct packed {
      logic       power_on;   // Output powered
      logic       gate;       // Output gated by the shutdown pin
      logic [1:0] dis_level;  // Level while suspended
   } csoc_out_cfg_t;
   // Per-output drive result
   typedef struct packed {
      logic run;    // Clock toggles
      logic level;  // Static level when stopped
      logic oe;     // Pin driven
   } csoc_out_drv_t;
   // Reference source state
   typedef enum logic { CSOC_ON_PRIMARY, CSOC_ON_SECONDARY } csoc_src_t;
endpackage

/* test/csoc_board.sv */
// Board-side model driving the select and control pins
`timescale 1ns/10ps
module csoc_board (
   // Clock
   input  wire logic                     clk,
   // Pins toward the block
   output logic [2:0]                    sel,
   output logic                          byp,
   output logic                          prim,
   output logic                          pick,
   output logic [1:0]                    mode,
   output logic                          xok,
   output logic                          eok,
   output logic                          pin,
   output logic                          pol,
   output logic                          sh,
   output csoc_pkg::csoc_out_cfg_t [5:0] cfg
);
   import csoc_pkg::*;
   // Quiet pins at time zero, both sources alive
   initial begin
      {sel, byp, prim, pick, mode, pin, pol, sh} = '0;
      {xok, eok} = 2'h3;
      cfg = '0;
   end
   // Selector; reserved codes only when a test asks
   task automatic set_sel(input logic [2:0] c, input bit rsv);
      @(negedge clk);
      sel = (c > 3'h5 && !rsv) ? sel : c;
   endtask
   // Source control bits
   task automatic set_src(input logic b, input logic p, input logic k, input logic [1:0] m);
      @(negedge clk);
      {byp, prim, pick, mode} = {b, p, k, m};
   endtask
   // Clock presence on each input
   task automatic set_ok(input logic x, input logic e);
      @(negedge clk);
      {xok, eok} = {x, e};
   endtask
   // Shutdown pin and output setup
   task automatic set_out(input logic n, input logic p, input logic s, input csoc_out_cfg_t [5:0] c);
      @(negedge clk);
      {pin, pol, sh} = {n, p, s};
      cfg = c;
   endtask
endmodule // csoc_board

/* test/testbench.sv */
// Self-checking bench for the clock source and output control block
`timescale 1ns/10ps
module testbench;
   import csoc_pkg::*;
   logic clk_sys = 1'b0;            // System clock
   logic reset_n = 1'b0;            // Active-low reset
   int   err_total = 0;             // Mismatches
   int   check_count = 0;           // Comparisons
   logic [2:0] sel, set_idx;        // Selector and loaded index
   logic [1:0] mode;                // Switchover mode
   logic byp, prim, pick, xok, eok, pin, pol, sh;
   logic set_ld, osc_byp, act_ext, on_sec, g_sd;
   logic [5:0] run, lvl, oe;        // Output drive results
   csoc_out_cfg_t [5:0] cfg;        // Output setup
   // Clock toggles every half period
   always #20 clk_sys = ~clk_sys;
   csoc_board board (.clk(clk_sys), .sel(sel), .byp(byp), .prim(prim), .pick(pick), .mode(mode),
      .xok(xok), .eok(eok), .pin(pin), .pol(pol), .sh(sh), .cfg(cfg));
   csoc_top DUT (.CLK_SYS(clk_sys), .RESET_N(reset_n), .SETTING_SEL(sel), .CRYSTAL_BYPASS(byp),
      .PRIMARY_SOURCE_CHOICE(prim), .SOURCE_PICK_PIN(pick), .SWITCHOVER_MODE(mode),
      .CRYSTAL_REF_OK(xok), .EXTERNAL_CLOCK_OK(eok), .SHUTDOWN_OR_GATE_PIN(pin),
      .PIN_POLARITY(pol), .SHUTDOWN_FUNCTION(sh), .OUT_CFG(cfg), .SETTING_INDEX(set_idx),
      .SETTING_LOAD(set_ld), .OSC_BYPASS(osc_byp), .ACTIVE_EXTERNAL(act_ext), .ON_SECONDARY(on_sec),
      .GLOBAL_SHUTDOWN(g_sd), .CLOCK_OUTPUT_RUN(run), .CLOCK_OUTPUT_LEVEL(lvl), .CLOCK_OUTPUT_OE(oe));
   // Compare and count
   task automatic chk(input logic [5:0] got, input logic [5:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Let one edge land
   task automatic step;
      @(posedge clk_sys);
      #1;
   endtask
   // Walk the selector, reserved codes last
   task automatic t_sel;
      for (int c = 1; c <= 7; c++) begin
         board.set_sel(c[2:0], 1'b1);
         step;
         chk(set_idx, (c > 5) ? 3'h5 : c[2:0], "index");
         chk(set_ld, c <= 5, "load pulse");
         step;
         chk(set_ld, 1'b0, "load drop");
      end
      $display("selector test done");
   endtask
   // Manual roles, then automatic and revertive switching
   task automatic t_src;
      for (int v = 7; v >= 0; v--) begin
         board.set_src(v[0], v[1], v[2], {1'b0, v[0]});
         step;
         chk(osc_byp, v[0], "bypass");
         chk(act_ext, v[1] ^ v[2], "active ext");
         chk(on_sec, v[2], "manual pick");
      end
      board.set_src(1'b0, 1'b0, 1'b0, 2'h2);
      board.set_ok(1'b0, 1'b1);
      step;
      chk(on_sec, 1'b1, "auto switch");
      chk(act_ext, 1'b1, "auto ext");
      board.set_ok(1'b1, 1'b1);
      step;
      step;
      chk(on_sec, 1'b1, "auto stays");
      board.set_src(1'b0, 1'b0, 1'b0, 2'h3);
      step;
      chk(on_sec, 1'b0, "revert");
      $display("source test done");
   endtask
   // Every pin, polarity, shutdown, power and gate mix
   task automatic t_out;
      csoc_out_cfg_t [5:0] cf;
      logic [5:0] er, el, eo;
      logic act, gsd, sus;
      for (int v = 0; v < 32; v++) begin
         for (int i = 0; i < 6; i++) cf[i] = {v[3], v[4], i[1:0]};
         board.set_out(v[0], v[1], v[2], cf);
         step;
         gsd = v[2] & v[0];
         act = v[0] != v[1];
         sus = gsd | (v[3] & v[4] & act);
         for (int i = 0; i < 6; i++) begin
            er[i] = !sus & v[3];
            eo[i] = sus ? !i[1] : v[3];
            el[i] = sus & !i[1] & i[0];
         end
         chk(g_sd, gsd, "shutdown");
         chk(run, er, "run");
         chk(oe, eo, "drive");
         chk(lvl, el, "level");
      end
      $display("output test done");
   endtask
   // Verdict and end of run
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      chk(set_idx, 3'h0, "reset index");
      @(negedge clk_sys) reset_n = 1'b1;
      t_sel;
      t_src;
      t_out;
      results;
   end
   // Watchdog
   initial begin
      #(40 * 1000);
      err_total++;
      $display("[FAIL] %0t watchdog", $time);
      results;
   end
endmodule // testbench
